// [rtl/dfp_consts.svh]
// Notes on behaviour
// - Frequency reference source 0..4, reset 1
// - Run command source 0..3, network needs 3
// - Bus error stop action 0..3, reset 1
// - External fault: always, or only while running
// - External fault stop action 0..3, reset 1
// - External fault action 3 only flags alarm
// - Multi-step references off at 0, on at 1
// - Drive init restores comm settings if enabled
// - Station 0..125; error light at 0 or above 125
// - Clear command zeroes or holds output data
// - Process map: 0 profile, 1 conventional
// - Station and map take effect after power cycle
// - Firmware 1012 on: comm init default becomes 1
// - Conventional layout used only when map is 1
`ifndef DFP_CONSTS_SVH
`define DFP_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DFP_OFS_FREQ_SRC 8'h00
`define DFP_OFS_RUN_SRC 8'h04
`define DFP_OFS_BUS_ACT 8'h08
`define DFP_OFS_EXT_COND 8'h0C
`define DFP_OFS_EXT_ACT 8'h10
`define DFP_OFS_MSTEP 8'h14
`define DFP_OFS_COMM_RST 8'h18
`define DFP_OFS_STATION 8'h1C
`define DFP_OFS_CLR_MODE 8'h20
`define DFP_OFS_MAP_SEL 8'h24
`define DFP_OFS_IRQ_STAT 8'h28
`define DFP_OFS_IRQ_MASK 8'h2C
`define DFP_OFS_ACTIVE 8'h30

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DFP_RST_FREQ 3'h1
`define DFP_RST_RUN 2'h1
`define DFP_RST_ACT 2'h1
`define DFP_RST_EXT_COND 1'h0
`define DFP_RST_MSTEP 1'h1
`define DFP_RST_COMM_OLD 1'h0
`define DFP_RST_COMM_NEW 1'h1
`define DFP_RST_STATION 7'h00
`define DFP_RST_CLR 1'h0
`define DFP_RST_MAP 1'h0

// ----------------------------------------------------------------
// Codes, limits and field positions
// ----------------------------------------------------------------
`define DFP_FREQ_MAX 3'h4
`define DFP_FREQ_OPTION 3'h3
`define DFP_RUN_OPTION 2'h3
`define DFP_STATION_MAX 7'h7D
`define DFP_FW_NEWDEF 16'h03F4
`define DFP_ACT_MAP_BIT 8
`define DFP_ACT_ERR_BIT 9
`define DFP_IRQ_BUS_ERR 0
`define DFP_IRQ_EXT_FLT 1
`define DFP_IRQ_CLEAR 2
`define DFP_IRQ_INIT 3

`endif

// [rtl/dfp_pkg.sv]
package dfp_pkg;

  // Stop action codes, in the order the settings encode them
  typedef enum logic [1:0] {
    DFP_STOP_RAMP,
    DFP_STOP_COAST,
    DFP_STOP_FAST,
    DFP_STOP_ALARM
  } dfp_stop_t;

  typedef struct packed {
    logic meta;
    logic q;
  } dfp_sync_t;

  typedef struct packed {
    logic [2:0] freq_ref_source_sel;
    logic [1:0] run_cmd_source_sel;
    dfp_stop_t bus_error_stop_action;
    logic ext_fault_detect_cond;
    dfp_stop_t ext_fault_stop_action;
    logic multistep_ref_mode;
    logic comm_param_init_reset;
    logic [6:0] station_number;
    logic clear_cmd_handling;
    logic process_map_select;
    logic [6:0] act_station;
    logic act_map;
    logic sampled;
    logic pwr_q;
    logic bus_q;
    logic ext_q;
    logic clr_q;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
    logic [15:0] out_data;
    logic stop_req;
    dfp_stop_t stop_kind;
    logic alarm;
    logic station_err;
    logic net_freq;
    logic net_run;
    logic irq;
  } dfp_state_t;

endpackage

// [rtl/dfp_sync2.sv]
`timescale 1ns/10ps
module dfp_sync2
  import dfp_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic d, // Asynchronous level in
  output logic q // Level in mclk domain
);

  dfp_sync_t state;
  dfp_sync_t next_state;

  always_comb begin
    next_state.meta = d;
    next_state.q = state.meta;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q = state.q;

endmodule

// [rtl/dfp_stop_sel.sv]
`timescale 1ns/10ps
module dfp_stop_sel
  import dfp_pkg::*;
(
  input wire logic fault_on, // Fault condition present
  input wire dfp_stop_t action, // Chosen response
  output logic stop_req, // Drive must stop
  output logic alarm // Alarm only, keep running
);

  // Alarm-only keeps the drive turning; the user must add a hard stop
  assign stop_req = fault_on && (action != DFP_STOP_ALARM);
  assign alarm = fault_on && (action == DFP_STOP_ALARM);

endmodule

// [rtl/dfp_param_bank.sv]
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "dfp_consts.svh"
module dfp_param_bank
  import dfp_pkg::*;
#(
  parameter logic [15:0] FW_VERSION = 16'h03F4
)
(
  input wire logic mclk, // System clock, 125 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic [7:0] addr, // Register byte address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [31:0] rdata, // Read data, cycle after rd
  input wire logic bus_error, // Fieldbus comm error level
  input wire logic network_external_fault, // Fault from network
  input wire logic drive_running, // Drive is running
  input wire logic drive_init_command, // Drive init pulse
  input wire logic clear_mode, // Master clear command level
  input wire logic [15:0] master_data, // Cyclic data from master
  input wire logic master_valid, // master_data is new
  input wire logic pwr_restart, // Power cycle pin, async
  output logic [2:0] freq_ref_source_sel, // Reference source
  output logic [1:0] run_cmd_source_sel, // Run command source
  output logic net_freq_ref_en, // Reference from option card
  output logic net_run_en, // Run/stop from option card
  output logic multistep_en, // Multi-step refs allowed
  output logic stop_req, // Stop request to drive core
  output logic [1:0] stop_kind, // Stop method code
  output logic fault_alarm, // Alarm without stop
  output logic station_err, // Error light
  output logic [6:0] active_station, // Station in effect
  output logic conventional_map, // Conventional layout active
  output logic [15:0] out_data, // Output data to drive
  output logic irq // Interrupt, level
);

  // ----------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------
  localparam logic RST_COMM = (FW_VERSION >= `DFP_FW_NEWDEF) ?
    `DFP_RST_COMM_NEW : `DFP_RST_COMM_OLD;

  localparam dfp_state_t RST_STATE = '{
    freq_ref_source_sel: `DFP_RST_FREQ,
    run_cmd_source_sel: `DFP_RST_RUN,
    bus_error_stop_action: dfp_stop_t'(`DFP_RST_ACT),
    ext_fault_detect_cond: `DFP_RST_EXT_COND,
    ext_fault_stop_action: dfp_stop_t'(`DFP_RST_ACT),
    multistep_ref_mode: `DFP_RST_MSTEP,
    comm_param_init_reset: RST_COMM,
    station_number: `DFP_RST_STATION,
    clear_cmd_handling: `DFP_RST_CLR,
    process_map_select: `DFP_RST_MAP,
    stop_kind: DFP_STOP_RAMP,
    default: '0
  };

  dfp_state_t state;
  dfp_state_t next_state;

  logic pwr_sync;
  logic pwr_rise;
  logic ext_hit;
  logic bus_stop;
  logic bus_alarm;
  logic ext_stop;
  logic ext_alarm;
  logic [3:0] ev;
  logic [3:0] w1c;
  logic init_apply;

  // ----------------------------------------------------------------
  // Power-cycle pin and fault resolution
  // ----------------------------------------------------------------
  dfp_sync2 u_pwr_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(pwr_restart),
    .q(pwr_sync)
  );

  assign pwr_rise = pwr_sync && !state.pwr_q;

  // Condition 1 masks the fault while stopped
  assign ext_hit = network_external_fault &&
    (!state.ext_fault_detect_cond || drive_running);

  dfp_stop_sel u_bus_sel (
    .fault_on(bus_error),
    .action(state.bus_error_stop_action),
    .stop_req(bus_stop),
    .alarm(bus_alarm)
  );

  dfp_stop_sel u_ext_sel (
    .fault_on(ext_hit),
    .action(state.ext_fault_stop_action),
    .stop_req(ext_stop),
    .alarm(ext_alarm)
  );

  assign init_apply = drive_init_command && state.comm_param_init_reset;

  always_comb begin
    ev = '0;
    ev[`DFP_IRQ_BUS_ERR] = bus_error && !state.bus_q;
    ev[`DFP_IRQ_EXT_FLT] = ext_hit && !state.ext_q;
    ev[`DFP_IRQ_CLEAR] = clear_mode && !state.clr_q;
    ev[`DFP_IRQ_INIT] = init_apply;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    w1c = '0;
    // Settings hold until written or restored
    if (wr) begin
      case (addr)
        `DFP_OFS_FREQ_SRC: begin
          // Codes above 4 name no source, so they are ignored
          if (wdata[2:0] <= `DFP_FREQ_MAX) begin
            next_state.freq_ref_source_sel = wdata[2:0];
          end
        end
        `DFP_OFS_RUN_SRC: next_state.run_cmd_source_sel = wdata[1:0];
        `DFP_OFS_BUS_ACT: begin
          next_state.bus_error_stop_action = dfp_stop_t'(wdata[1:0]);
        end
        `DFP_OFS_EXT_COND: next_state.ext_fault_detect_cond = wdata[0];
        `DFP_OFS_EXT_ACT: begin
          next_state.ext_fault_stop_action = dfp_stop_t'(wdata[1:0]);
        end
        `DFP_OFS_MSTEP: next_state.multistep_ref_mode = wdata[0];
        `DFP_OFS_COMM_RST: next_state.comm_param_init_reset = wdata[0];
        `DFP_OFS_STATION: next_state.station_number = wdata[6:0];
        `DFP_OFS_CLR_MODE: next_state.clear_cmd_handling = wdata[0];
        `DFP_OFS_MAP_SEL: next_state.process_map_select = wdata[0];
        `DFP_OFS_IRQ_STAT: w1c = wdata[3:0];
        `DFP_OFS_IRQ_MASK: next_state.irq_mask = wdata[3:0];
        default: begin
        end
      endcase
    end

    // Init overrides a write to the same settings in the same cycle
    if (init_apply) begin
      next_state.bus_error_stop_action = RST_STATE.bus_error_stop_action;
      next_state.ext_fault_detect_cond = RST_STATE.ext_fault_detect_cond;
      next_state.ext_fault_stop_action = RST_STATE.ext_fault_stop_action;
      next_state.multistep_ref_mode = RST_STATE.multistep_ref_mode;
      next_state.comm_param_init_reset = RST_STATE.comm_param_init_reset;
      next_state.station_number = RST_STATE.station_number;
      next_state.clear_cmd_handling = RST_STATE.clear_cmd_handling;
      next_state.process_map_select = RST_STATE.process_map_select;
    end

    // Station and map are taken once after reset and on each power
    // cycle; later writes wait for the next one
    if (!state.sampled || pwr_rise) begin
      next_state.act_station = state.station_number;
      next_state.act_map = state.process_map_select;
      next_state.sampled = 1'b1;
    end
    next_state.pwr_q = pwr_sync;
    next_state.bus_q = bus_error;
    next_state.ext_q = ext_hit;
    next_state.clr_q = clear_mode;

    // An event in the clearing cycle survives the clear
    next_state.irq_stat = (state.irq_stat & ~w1c) | ev;
    next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

    next_state.rdata = '0;
    if (rd) begin
      case (addr)
        `DFP_OFS_FREQ_SRC: next_state.rdata[2:0] = state.freq_ref_source_sel;
        `DFP_OFS_RUN_SRC: next_state.rdata[1:0] = state.run_cmd_source_sel;
        `DFP_OFS_BUS_ACT: begin
          next_state.rdata[1:0] = state.bus_error_stop_action;
        end
        `DFP_OFS_EXT_COND: next_state.rdata[0] = state.ext_fault_detect_cond;
        `DFP_OFS_EXT_ACT: begin
          next_state.rdata[1:0] = state.ext_fault_stop_action;
        end
        `DFP_OFS_MSTEP: next_state.rdata[0] = state.multistep_ref_mode;
        `DFP_OFS_COMM_RST: next_state.rdata[0] = state.comm_param_init_reset;
        `DFP_OFS_STATION: next_state.rdata[6:0] = state.station_number;
        `DFP_OFS_CLR_MODE: next_state.rdata[0] = state.clear_cmd_handling;
        `DFP_OFS_MAP_SEL: next_state.rdata[0] = state.process_map_select;
        `DFP_OFS_IRQ_STAT: next_state.rdata[3:0] = state.irq_stat;
        `DFP_OFS_IRQ_MASK: next_state.rdata[3:0] = state.irq_mask;
        `DFP_OFS_ACTIVE: begin
          next_state.rdata[6:0] = state.act_station;
          next_state.rdata[`DFP_ACT_MAP_BIT] = state.act_map;
          next_state.rdata[`DFP_ACT_ERR_BIT] = state.station_err;
        end
        default: next_state.rdata = '0;
      endcase
    end

    // Bus error sets the stop kind when both are present; a stop from either source masks the other's alarm
    next_state.stop_req = bus_stop || ext_stop;
    next_state.alarm = (bus_alarm && !ext_stop) ||
      (ext_alarm && !bus_stop);
    if (bus_error) begin
      next_state.stop_kind = state.bus_error_stop_action;
    end else if (ext_hit) begin
      next_state.stop_kind = state.ext_fault_stop_action;
    end else begin
      next_state.stop_kind = DFP_STOP_RAMP;
    end

    next_state.station_err = (state.station_number == 7'h00) ||
      (state.station_number > `DFP_STATION_MAX);

    if (clear_mode) begin
      if (!state.clear_cmd_handling) begin
        next_state.out_data = 16'h0000;
      end
    end else if (master_valid) begin
      next_state.out_data = master_data;
    end

    next_state.net_freq =
      (next_state.freq_ref_source_sel == `DFP_FREQ_OPTION);
    next_state.net_run =
      (next_state.run_cmd_source_sel == `DFP_RUN_OPTION);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= RST_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = state.rdata;
  assign freq_ref_source_sel = state.freq_ref_source_sel;
  assign run_cmd_source_sel = state.run_cmd_source_sel;
  assign net_freq_ref_en = state.net_freq;
  assign net_run_en = state.net_run;
  assign multistep_en = state.multistep_ref_mode;
  assign stop_req = state.stop_req;
  assign stop_kind = state.stop_kind;
  assign fault_alarm = state.alarm;
  assign station_err = state.station_err;
  assign active_station = state.act_station;
  assign conventional_map = state.act_map;
  assign out_data = state.out_data;
  assign irq = state.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_freq_range: assert property (
    @(posedge mclk) disable iff (!rst_b)
    freq_ref_source_sel <= `DFP_FREQ_MAX)
    else $error("frequency source out of range");

  chk_net_run: assert property (
    @(posedge mclk) disable iff (!rst_b)
    net_run_en == (run_cmd_source_sel == `DFP_RUN_OPTION))
    else $error("network run enable wrong");

  chk_bus_stop: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_error && state.bus_error_stop_action != DFP_STOP_ALARM
    |=> stop_req && stop_kind == $past(state.bus_error_stop_action))
    else $error("bus error stop missing");

  chk_ext_masked: assert property (
    @(posedge mclk) disable iff (!rst_b)
    network_external_fault && state.ext_fault_detect_cond &&
    !drive_running && !bus_error |=> !stop_req && !fault_alarm)
    else $error("external fault not masked while stopped");

  chk_ext_stop: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ext_hit && !bus_error &&
    state.ext_fault_stop_action != DFP_STOP_ALARM
    |=> stop_req && stop_kind == $past(state.ext_fault_stop_action))
    else $error("external fault stop missing");

  chk_alarm_only: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ext_hit && !bus_error &&
    state.ext_fault_stop_action == DFP_STOP_ALARM
    |=> fault_alarm && !stop_req)
    else $error("alarm-only fault stopped the drive");

  chk_init_restore: assert property (
    @(posedge mclk) disable iff (!rst_b)
    drive_init_command && state.comm_param_init_reset
    |=> multistep_en && state.station_number == `DFP_RST_STATION &&
        state.bus_error_stop_action == DFP_STOP_COAST)
    else $error("init did not restore settings");

  chk_init_keep: assert property (
    @(posedge mclk) disable iff (!rst_b)
    drive_init_command && !state.comm_param_init_reset && !wr
    |=> $stable(state.station_number) && $stable(multistep_en))
    else $error("init changed settings while disabled");

  chk_station_err: assert property (
    @(posedge mclk) disable iff (!rst_b)
    state.sampled && (state.station_number == 7'h00 ||
    state.station_number > `DFP_STATION_MAX) |=> station_err)
    else $error("error light off for station zero");

  chk_clear_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clear_mode && !state.clear_cmd_handling |=> out_data == 16'h0000)
    else $error("output data not cleared");

  chk_clear_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    clear_mode && state.clear_cmd_handling |=> $stable(out_data))
    else $error("output data not held");

  chk_map_latch: assert property (
    @(posedge mclk) disable iff (!rst_b)
    state.sampled && !pwr_rise
    |=> $stable(active_station) && $stable(conventional_map))
    else $error("active station changed without power cycle");

  chk_irq_sticky: assert property (
    @(posedge mclk) disable iff (!rst_b)
    bus_error && !state.bus_q |=> state.irq_stat[`DFP_IRQ_BUS_ERR])
    else $error("bus error event lost");

endmodule

// [verification/dfp_master_model.sv]
`timescale 1ns/10ps
module dfp_master_model
  import dfp_pkg::*;
#(
  parameter logic [6:0] OWN_STATION = 7'h01 // Master stays off drive numbers
)
(
  output logic bus_error, // Comm error level
  output logic network_external_fault, // External fault level
  output logic drive_running, // Drive core running
  output logic drive_init_command, // Init pulse
  output logic clear_mode, // Clear command level
  output logic [15:0] master_data, // Cyclic data
  output logic master_valid, // Data strobe
  output logic pwr_restart, // Power cycle pin
  input wire logic mclk // System clock
);
  initial begin
    bus_error = 1'h0;
    network_external_fault = 1'h0;
    drive_running = 1'h0;
    drive_init_command = 1'h0;
    clear_mode = 1'h0;
    master_data = 16'h0;
    master_valid = 1'h0;
    pwr_restart = 1'h0;
  end

  task automatic levels(input logic be, ef, run, clr);
    @(posedge mclk);
    bus_error <= be;
    network_external_fault <= ef;
    drive_running <= run;
    clear_mode <= clr;
  endtask

  // Data line is not held after the strobe, so stale use shows up
  task automatic send(input logic [15:0] d);
    @(posedge mclk);
    master_data <= d;
    master_valid <= 1'h1;
    @(posedge mclk);
    master_valid <= 1'h0;
    master_data <= ~d;
  endtask

  task automatic init_pulse();
    @(posedge mclk);
    drive_init_command <= 1'h1;
    @(posedge mclk);
    drive_init_command <= 1'h0;
  endtask

  task automatic power_cycle();
    @(posedge mclk);
    pwr_restart <= 1'h1;
    repeat (4) @(posedge mclk);
    pwr_restart <= 1'h0;
  endtask
endmodule

// [verification/dfp_param_bank_tb.sv]
`timescale 1ns/10ps
`include "dfp_consts.svh"
module dfp_param_bank_tb
  import dfp_pkg::*;
;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] rdata;
  logic be, ef, run, init, clr, mvalid, pwr;
  logic [15:0] mdata, out_data;
  logic [2:0] freq_sel;
  logic [1:0] run_sel, stop_kind;
  logic net_freq, net_run, mstep, stop_req, alarm, st_err, cmap, irq;
  logic [6:0] act_st;
  int errors = 0;
  int n_checks = 0;
  // Reset value of registers 00..2C, one bit each
  localparam logic [11:0] RST_EXP = 12'h077;

  always #4 mclk = ~mclk;

  dfp_param_bank dfp_param_bank_inst (.mclk(mclk), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .bus_error(be), .network_external_fault(ef), .drive_running(run),
    .drive_init_command(init), .clear_mode(clr), .master_data(mdata),
    .master_valid(mvalid), .pwr_restart(pwr),
    .freq_ref_source_sel(freq_sel), .run_cmd_source_sel(run_sel),
    .net_freq_ref_en(net_freq), .net_run_en(net_run),
    .multistep_en(mstep), .stop_req(stop_req), .stop_kind(stop_kind),
    .fault_alarm(alarm), .station_err(st_err),
    .active_station(act_st), .conventional_map(cmap),
    .out_data(out_data), .irq(irq));

  dfp_master_model dfp_master_model_inst (.bus_error(be),
    .network_external_fault(ef), .drive_running(run),
    .drive_init_command(init), .clear_mode(clr), .master_data(mdata),
    .master_valid(mvalid), .pwr_restart(pwr), .mclk(mclk));

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    chk(rdata, e);
  endtask

  // Packs stop outputs as {stop_req, alarm, kind}; a < 0 means no fault
  // Alarm only still shows its action code on the kind lines
  task automatic chk_stop(input int a);
    chk({28'h0, stop_req, alarm, stop_kind},
        (a < 0) ? 32'h0 : ((a == 3) ? 32'h7 : (32'h8 | 32'(a))));
  endtask

  task automatic done(input string s);
    $display("test %s done, mismatches so far %0d", s, errors);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    cyc(2);
    for (int i = 0; i < 12; i++) begin
      rd_chk(8'(4 * i), {31'h0, RST_EXP[i]});
    end
    rd_chk(`DFP_OFS_ACTIVE, 32'h200);
    done("reset");

    for (int i = 0; i < 5; i++) begin
      wr_reg(`DFP_OFS_FREQ_SRC, 32'(i));
      wr_reg(`DFP_OFS_RUN_SRC, 32'(i % 4));
      cyc(2);
      chk({29'h0, freq_sel}, 32'(i));
      chk({31'h0, net_freq}, {31'h0, i == 3});
      chk({30'h0, run_sel}, 32'(i % 4));
      chk({31'h0, net_run}, {31'h0, i == 3});
    end
    wr_reg(`DFP_OFS_FREQ_SRC, 32'h5);
    rd_chk(`DFP_OFS_FREQ_SRC, 32'h4);
    wr_reg(8'h3C, 32'hFF);
    rd_chk(8'h3C, 32'h0);
    done("sources");

    for (int a = 0; a < 4; a++) begin
      wr_reg(`DFP_OFS_BUS_ACT, 32'(a));
      wr_reg(`DFP_OFS_EXT_ACT, 32'(a));
      dfp_master_model_inst.levels(1'h1, 1'h0, 1'h0, 1'h0);
      cyc(2);
      chk_stop(a);
      dfp_master_model_inst.levels(1'h0, 1'h1, 1'h0, 1'h0);
      cyc(2);
      chk_stop(a);
      dfp_master_model_inst.levels(1'h0, 1'h0, 1'h0, 1'h0);
      cyc(2);
      chk_stop(-1);
    end
    wr_reg(`DFP_OFS_EXT_ACT, 32'h2);
    wr_reg(`DFP_OFS_EXT_COND, 32'h1);
    dfp_master_model_inst.levels(1'h0, 1'h1, 1'h0, 1'h0);
    cyc(2);
    chk({28'h0, stop_req, alarm, stop_kind}, 32'h0);
    dfp_master_model_inst.levels(1'h0, 1'h1, 1'h1, 1'h0);
    cyc(2);
    chk_stop(2);
    dfp_master_model_inst.levels(1'h0, 1'h0, 1'h0, 1'h0);
    done("faults");

    wr_reg(`DFP_OFS_IRQ_STAT, 32'hF);
    dfp_master_model_inst.levels(1'h1, 1'h0, 1'h0, 1'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`DFP_OFS_IRQ_STAT, 32'h1);
    wr_reg(`DFP_OFS_IRQ_MASK, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    dfp_master_model_inst.levels(1'h0, 1'h0, 1'h0, 1'h0);
    wr_reg(`DFP_OFS_IRQ_STAT, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`DFP_OFS_IRQ_STAT, 32'h0);
    done("interrupt");

    wr_reg(`DFP_OFS_MSTEP, 32'h0);
    cyc(2);
    chk({31'h0, mstep}, 32'h0);
    wr_reg(`DFP_OFS_MSTEP, 32'h1);
    cyc(2);
    chk({31'h0, mstep}, 32'h1);
    wr_reg(`DFP_OFS_COMM_RST, 32'h0);
    wr_reg(`DFP_OFS_BUS_ACT, 32'h2);
    dfp_master_model_inst.init_pulse();
    cyc(2);
    rd_chk(`DFP_OFS_BUS_ACT, 32'h2);
    wr_reg(`DFP_OFS_COMM_RST, 32'h1);
    dfp_master_model_inst.init_pulse();
    cyc(2);
    rd_chk(`DFP_OFS_BUS_ACT, 32'h1);
    rd_chk(`DFP_OFS_EXT_COND, 32'h0);
    rd_chk(`DFP_OFS_COMM_RST, 32'h1);
    done("init");

    wr_reg(`DFP_OFS_STATION, 32'h7D);
    cyc(2);
    chk({31'h0, st_err}, 32'h0);
    wr_reg(`DFP_OFS_STATION, 32'h7E);
    cyc(2);
    chk({31'h0, st_err}, 32'h1);
    wr_reg(`DFP_OFS_STATION, 32'h5);
    wr_reg(`DFP_OFS_MAP_SEL, 32'h1);
    cyc(2);
    chk({31'h0, st_err}, 32'h0);
    rd_chk(`DFP_OFS_MAP_SEL, 32'h1);
    chk({24'h0, cmap, act_st}, 32'h0);
    dfp_master_model_inst.power_cycle();
    cyc(6);
    chk({24'h0, cmap, act_st}, 32'h85);
    rd_chk(`DFP_OFS_ACTIVE, 32'h105);
    done("station");

    dfp_master_model_inst.send(16'hA5C3);
    cyc(2);
    chk({16'h0, out_data}, 32'hA5C3);
    dfp_master_model_inst.levels(1'h0, 1'h0, 1'h0, 1'h1);
    cyc(2);
    chk({16'h0, out_data}, 32'h0);
    dfp_master_model_inst.levels(1'h0, 1'h0, 1'h0, 1'h0);
    wr_reg(`DFP_OFS_CLR_MODE, 32'h1);
    dfp_master_model_inst.send(16'h3C5A);
    dfp_master_model_inst.levels(1'h0, 1'h0, 1'h0, 1'h1);
    dfp_master_model_inst.send(16'h1234);
    cyc(2);
    chk({16'h0, out_data}, 32'h3C5A);
    dfp_master_model_inst.levels(1'h0, 1'h0, 1'h0, 1'h0);
    done("clear");
    tally_and_finish();
  end
endmodule
